// ---- inc/asnr_pkg.sv ----
// Constants and carrier types for the status and network register bank
package asnr_pkg;

  // Register offsets
  localparam logic [7:0] OFS_SEL_MASK   = 8'h0f;
  localparam logic [7:0] OFS_IP_HI      = 8'h43;
  localparam logic [7:0] OFS_IP_LO      = 8'h44;
  localparam logic [7:0] OFS_GW_HI      = 8'h45;
  localparam logic [7:0] OFS_GW_LO      = 8'h46;
  localparam logic [7:0] OFS_NM_HI      = 8'h47;
  localparam logic [7:0] OFS_NM_LO      = 8'h48;
  localparam logic [7:0] OFS_FLAGS      = 8'h97;
  localparam logic [7:0] OFS_COMMAND    = 8'h20;
  localparam logic [7:0] OFS_TEMP_UNIT  = 8'h21;
  localparam logic [7:0] OFS_PRES_UNIT  = 8'h22;
  localparam logic [7:0] OFS_DP_SETPT   = 8'h23;
  localparam logic [7:0] OFS_ENC_SETPT  = 8'h24;
  localparam logic [7:0] OFS_PRES_SETPT = 8'h25;

  // Network defaults
  localparam logic [15:0] RST_IP_HI = 16'hc0a8;
  localparam logic [15:0] RST_IP_LO = 16'h0103;
  localparam logic [15:0] RST_GW_HI = 16'hc0a8;
  localparam logic [15:0] RST_GW_LO = 16'h01fe;
  localparam logic [15:0] RST_NM_HI = 16'hffff;
  localparam logic [15:0] RST_NM_LO = 16'hff00;

  // Other reset values and the implemented status flag mask
  localparam logic [15:0] RST_SEL_MASK   = 16'h0fdf;
  localparam logic [15:0] RST_UNIT       = 16'h0000;
  localparam logic [15:0] RST_DP_SETPT   = 16'h0000;
  localparam logic [15:0] RST_ENC_SETPT  = 16'h0032;
  localparam logic [15:0] RST_PRES_SETPT = 16'h03e8;
  localparam logic [15:0] IMPL_FLAG_MASK = 16'h0fdf;

  // Command codes
  localparam logic [15:0] CMD_CLEAR_LATCH  = 16'h0018;
  localparam logic [15:0] CMD_NET_DEFAULTS = 16'h0028;
  localparam logic [15:0] CMD_NET_USER     = 16'h0029;

  // Status flag positions
  localparam int BIT_MIRROR_SENSOR = 0;
  localparam int BIT_ENC_SENSOR    = 1;
  localparam int BIT_CELL_PRES     = 2;
  localparam int BIT_EXT_PRES      = 3;
  localparam int BIT_COOLER_SHORT  = 4;
  localparam int BIT_CONTAMINATION = 5;
  localparam int BIT_RECOVERY      = 6;
  localparam int BIT_DEW_NOT_REACH = 7;
  localparam int BIT_CYCLE_EXPIRED = 8;
  localparam int BIT_ENC_RANGE     = 9;
  localparam int BIT_WATER         = 10;
  localparam int BIT_SENSOR_BOARD  = 11;

  // Enclosure temperature limits, whole degrees C
  localparam logic signed [15:0] ENC_TEMP_MIN = -16'sd20;
  localparam logic signed [15:0] ENC_TEMP_MAX = 16'sd70;

  // Display thresholds, moisture in hundredths
  localparam logic [31:0] DISP_TWO_DP_MAX = 32'h0001869f;
  localparam logic [31:0] DISP_ONE_DP_MAX = 32'h000f423f;

  typedef struct packed {
    logic mirror_sensor_open;
    logic enc_sensor_open;
    logic cell_pres_bad;
    logic ext_pres_bad;
    logic ext_sensor_present;
    logic cooler_short;
    logic recovery_fail;
    logic min_cool_reached;
    logic max_cool_reached;
    logic cycle_expired;
    logic water_detected;
    logic board_link_error;
    logic board_unconfigured;
  } asnr_cond_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        fieldbus;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } asnr_req_t;

endpackage : asnr_pkg

// ---- design/asnr_regs.sv ----
// Status flags, alarm selection mask and network address register bank
// Operation
// - Latch bit 0 on mirror sensor open/short, bit 1 on enclosure sensor.
// - Latch bit 2 on cell pressure sensor fault or pressure out of range.
// - Latch bit 3 on external pressure fault only with external sensor connected.
// - Latch bit 4 on cooler drive output short circuit.
// - Bit 5 contamination warning is never set.
// - Bit 6 on recovery heating failure; bit 7 on cooling limit before dew point.
// - Bit 8 when measurement overruns the cycle time.
// - Bit 9 when enclosure temperature is below -20 or above +70 C.
// - Bit 10 when water forms on the mirror.
// - Bit 11 on sensor board link error or unconfigured board.
// - Relay and third output fault follow flags enabled by mask register 15.
// - Defaults load on command 40 written locally, not over the fieldbus, or while the default switch is set.
// - Network registers hold high octet in bits 15:8, low octet 7:0.
// - Integer-format range and setpoint registers store signed 16-bit words.
// - Tenths-format pressure registers store ten times the value, signed.
// - Changing temperature or pressure unit restores dependent setpoints to defaults.
// - Display shows two decimals to 999.99, one to 9999.9, else none.
// - Command 24 clears latched flags, relay and third output fault.
`timescale 1ns/1ps
module asnr_regs (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  input  wire asnr_pkg::asnr_req_t  req_i,
  input  wire asnr_pkg::asnr_cond_t cond_i,
  input  wire logic signed [15:0]   enc_temp_i,
  input  wire logic                 default_select_switch_i,
  input  wire logic [31:0]          moisture_i,
  output logic [15:0]               rdata_o,
  output logic                      status_alarm_relay_o,
  output logic                      third_output_fault_o,
  output logic [1:0]                display_decimals_o
);
  import asnr_pkg::*;

  logic [15:0]        mask_q;
  logic [15:0]        ip_hi_q;
  logic [15:0]        ip_lo_q;
  logic [15:0]        gw_hi_q;
  logic [15:0]        gw_lo_q;
  logic [15:0]        nm_hi_q;
  logic [15:0]        nm_lo_q;
  logic [15:0]        flags_q;
  logic [15:0]        temp_unit_q;
  logic [15:0]        pres_unit_q;
  logic signed [15:0] dp_setpt_q;
  logic signed [15:0] enc_setpt_q;
  logic signed [15:0] pres_setpt_q;
  logic [15:0]        rdata_q;
  logic               relay_q;
  logic               fault_q;
  logic [1:0]         dp_q;

  logic [15:0]        set_vec;
  logic               cmd_wr;
  logic               clear_cmd;
  logic               net_dflt;
  logic               temp_chg;
  logic               pres_chg;

  function automatic logic wr_at(input asnr_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : wr_at

  assign cmd_wr    = wr_at(req_i, OFS_COMMAND);
  assign clear_cmd = cmd_wr && (req_i.wdata == CMD_CLEAR_LATCH);
  // Fieldbus writes of the network commands do nothing
  assign net_dflt  = default_select_switch_i
                   || (cmd_wr && !req_i.fieldbus && (req_i.wdata == CMD_NET_DEFAULTS));
  assign temp_chg  = wr_at(req_i, OFS_TEMP_UNIT) && (req_i.wdata != temp_unit_q);
  assign pres_chg  = wr_at(req_i, OFS_PRES_UNIT) && (req_i.wdata != pres_unit_q);

  always_comb begin
    set_vec = 16'h0000;
    set_vec[BIT_MIRROR_SENSOR] = cond_i.mirror_sensor_open;
    set_vec[BIT_ENC_SENSOR]    = cond_i.enc_sensor_open;
    set_vec[BIT_CELL_PRES]     = cond_i.cell_pres_bad;
    set_vec[BIT_EXT_PRES]      = cond_i.ext_pres_bad && cond_i.ext_sensor_present;
    set_vec[BIT_COOLER_SHORT]  = cond_i.cooler_short;
    set_vec[BIT_CONTAMINATION] = 1'b0;
    set_vec[BIT_RECOVERY]      = cond_i.recovery_fail;
    set_vec[BIT_DEW_NOT_REACH] = cond_i.min_cool_reached || cond_i.max_cool_reached;
    set_vec[BIT_CYCLE_EXPIRED] = cond_i.cycle_expired;
    set_vec[BIT_ENC_RANGE]     = (enc_temp_i < ENC_TEMP_MIN) || (enc_temp_i > ENC_TEMP_MAX);
    set_vec[BIT_WATER]         = cond_i.water_detected;
    set_vec[BIT_SENSOR_BOARD]  = cond_i.board_link_error || cond_i.board_unconfigured;
  end

  // Flags latch; a live condition survives the clear command
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= ((clear_cmd ? 16'h0000 : flags_q) | set_vec) & IMPL_FLAG_MASK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_q <= RST_SEL_MASK;
    end else if (wr_at(req_i, OFS_SEL_MASK)) begin
      mask_q <= req_i.wdata;
    end
  end

  // Outputs follow the masked latched flags one cycle later, so they clear one cycle after them
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      relay_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      relay_q <= |(flags_q & mask_q);
      fault_q <= |(flags_q & mask_q);
    end
  end

  // Each word is two octets, high in 15:8
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ip_hi_q <= RST_IP_HI;
      ip_lo_q <= RST_IP_LO;
      gw_hi_q <= RST_GW_HI;
      gw_lo_q <= RST_GW_LO;
      nm_hi_q <= RST_NM_HI;
      nm_lo_q <= RST_NM_LO;
    end else if (net_dflt) begin
      ip_hi_q <= RST_IP_HI;
      ip_lo_q <= RST_IP_LO;
      gw_hi_q <= RST_GW_HI;
      gw_lo_q <= RST_GW_LO;
      nm_hi_q <= RST_NM_HI;
      nm_lo_q <= RST_NM_LO;
    end else begin
      if (wr_at(req_i, OFS_IP_HI)) ip_hi_q <= req_i.wdata;
      if (wr_at(req_i, OFS_IP_LO)) ip_lo_q <= req_i.wdata;
      if (wr_at(req_i, OFS_GW_HI)) gw_hi_q <= req_i.wdata;
      if (wr_at(req_i, OFS_GW_LO)) gw_lo_q <= req_i.wdata;
      if (wr_at(req_i, OFS_NM_HI)) nm_hi_q <= req_i.wdata;
      if (wr_at(req_i, OFS_NM_LO)) nm_lo_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_unit_q <= RST_UNIT;
      pres_unit_q <= RST_UNIT;
    end else begin
      if (wr_at(req_i, OFS_TEMP_UNIT)) temp_unit_q <= req_i.wdata;
      if (wr_at(req_i, OFS_PRES_UNIT)) pres_unit_q <= req_i.wdata;
    end
  end

  // Unit change wins over a same-cycle setpoint write
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dp_setpt_q   <= RST_DP_SETPT;
      enc_setpt_q  <= RST_ENC_SETPT;
      pres_setpt_q <= RST_PRES_SETPT;
    end else begin
      if (temp_chg) begin
        dp_setpt_q  <= RST_DP_SETPT;
        enc_setpt_q <= RST_ENC_SETPT;
      end else begin
        if (wr_at(req_i, OFS_DP_SETPT))  dp_setpt_q  <= req_i.wdata;
        if (wr_at(req_i, OFS_ENC_SETPT)) enc_setpt_q <= req_i.wdata;
      end
      if (pres_chg) begin
        pres_setpt_q <= RST_PRES_SETPT;
      end else if (wr_at(req_i, OFS_PRES_SETPT)) begin
        pres_setpt_q <= req_i.wdata;
      end
    end
  end

  // Read answers one cycle later; unmapped and command read zero
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 16'h0000;
    end else if (req_i.rd) begin
      case (req_i.addr)
        OFS_SEL_MASK:   rdata_q <= mask_q;
        OFS_IP_HI:      rdata_q <= ip_hi_q;
        OFS_IP_LO:      rdata_q <= ip_lo_q;
        OFS_GW_HI:      rdata_q <= gw_hi_q;
        OFS_GW_LO:      rdata_q <= gw_lo_q;
        OFS_NM_HI:      rdata_q <= nm_hi_q;
        OFS_NM_LO:      rdata_q <= nm_lo_q;
        OFS_FLAGS:      rdata_q <= flags_q;
        OFS_TEMP_UNIT:  rdata_q <= temp_unit_q;
        OFS_PRES_UNIT:  rdata_q <= pres_unit_q;
        OFS_DP_SETPT:   rdata_q <= dp_setpt_q;
        OFS_ENC_SETPT:  rdata_q <= enc_setpt_q;
        OFS_PRES_SETPT: rdata_q <= pres_setpt_q;
        default:        rdata_q <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dp_q <= 2'h2;
    end else if (moisture_i <= DISP_TWO_DP_MAX) begin
      dp_q <= 2'h2;
    end else if (moisture_i <= DISP_ONE_DP_MAX) begin
      dp_q <= 2'h1;
    end else begin
      dp_q <= 2'h0;
    end
  end

  assign rdata_o              = rdata_q;
  assign status_alarm_relay_o = relay_q;
  assign third_output_fault_o = fault_q;
  assign display_decimals_o   = dp_q;

  a_reserved_bits_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (flags_q[15:12] == 4'h0) && !flags_q[BIT_CONTAMINATION])
    else $error("reserved status bits set");

  a_mirror_flag_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.mirror_sensor_open |=> flags_q[BIT_MIRROR_SENSOR])
    else $error("mirror fault not latched");

  a_ext_pres_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !flags_q[BIT_EXT_PRES] && !cond_i.ext_sensor_present |=> !flags_q[BIT_EXT_PRES])
    else $error("external pressure flag set without sensor");

  a_enc_temp_range: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (enc_temp_i > ENC_TEMP_MAX) || (enc_temp_i < ENC_TEMP_MIN) |=> flags_q[BIT_ENC_RANGE])
    else $error("enclosure range flag missing");

  a_relay_masked: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 (relay_q == |($past(flags_q) & $past(mask_q))) && (fault_q == relay_q))
    else $error("relay does not follow masked flags");

  a_net_defaults: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    default_select_switch_i |=> (ip_hi_q == RST_IP_HI) && (ip_lo_q == RST_IP_LO) && (gw_lo_q == RST_GW_LO)
      && (nm_lo_q == RST_NM_LO))
    else $error("network defaults not loaded");

  a_fieldbus_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cmd_wr && req_i.fieldbus && !default_select_switch_i |=> $stable(ip_hi_q) && $stable(nm_lo_q))
    else $error("fieldbus network command acted");

  a_clear_latched: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clear_cmd && (set_vec == 16'h0000) |=> (flags_q == 16'h0000) ##1 !relay_q)
    else $error("clear command left flags or relay");

  a_unit_restore: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    pres_chg |=> pres_setpt_q == RST_PRES_SETPT)
    else $error("pressure setpoint not restored");

  a_display_dp: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    moisture_i > DISP_ONE_DP_MAX |=> display_decimals_o == 2'h0)
    else $error("display decimals wrong");

  a_enc_flag_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.enc_sensor_open |=> flags_q[BIT_ENC_SENSOR])
    else $error("enclosure sensor fault not latched");

  a_cell_pres_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.cell_pres_bad |=> flags_q[BIT_CELL_PRES])
    else $error("cell pressure fault not latched");

  a_ext_pres_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.ext_pres_bad && cond_i.ext_sensor_present |=> flags_q[BIT_EXT_PRES])
    else $error("external pressure fault not latched");

  a_cooler_short_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.cooler_short |=> flags_q[BIT_COOLER_SHORT])
    else $error("cooler short not latched");

  a_recovery_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.recovery_fail |=> flags_q[BIT_RECOVERY])
    else $error("recovery warning not latched");

  a_dew_limit_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.min_cool_reached || cond_i.max_cool_reached |=> flags_q[BIT_DEW_NOT_REACH])
    else $error("cooling limit warning not latched");

  a_cycle_expired_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.cycle_expired |=> flags_q[BIT_CYCLE_EXPIRED])
    else $error("cycle overrun warning not latched");

  a_water_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.water_detected |=> flags_q[BIT_WATER])
    else $error("water warning not latched");

  a_board_warn_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cond_i.board_link_error || cond_i.board_unconfigured |=> flags_q[BIT_SENSOR_BOARD])
    else $error("sensor board warning not latched");

  a_enc_range_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !flags_q[BIT_ENC_RANGE] && (enc_temp_i >= ENC_TEMP_MIN) && (enc_temp_i <= ENC_TEMP_MAX)
      |=> !flags_q[BIT_ENC_RANGE])
    else $error("enclosure range flag set in range");

  a_flags_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !clear_cmd |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("latched flag lost without clear");

  a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_at(req_i, OFS_SEL_MASK) |=> (mask_q == $past(req_i.wdata)))
    else $error("selection mask not written");

  a_net_cmd_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cmd_wr && !req_i.fieldbus && (req_i.wdata == CMD_NET_DEFAULTS)
      |=> (ip_hi_q == RST_IP_HI) && (gw_hi_q == RST_GW_HI) && (nm_hi_q == RST_NM_HI))
    else $error("network default command not honoured");

  a_net_word_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_at(req_i, OFS_GW_LO) && !default_select_switch_i |=> (gw_lo_q == $past(req_i.wdata)))
    else $error("network word not written");

  a_int_setpt: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_at(req_i, OFS_ENC_SETPT) |=> (enc_setpt_q == $past(req_i.wdata)))
    else $error("integer setpoint not stored");

  a_tenths_setpt: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_at(req_i, OFS_PRES_SETPT) |=> (pres_setpt_q == $past(req_i.wdata)))
    else $error("tenths setpoint not stored");

  a_temp_restore: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    temp_chg |=> (dp_setpt_q == RST_DP_SETPT) && (enc_setpt_q == RST_ENC_SETPT))
    else $error("temperature setpoints not restored");

  a_display_two: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    moisture_i <= DISP_TWO_DP_MAX |=> display_decimals_o == 2'h2)
    else $error("display should show two decimals");

  a_display_one: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (moisture_i > DISP_TWO_DP_MAX) && (moisture_i <= DISP_ONE_DP_MAX) |=> display_decimals_o == 2'h1)
    else $error("display should show one decimal");

  a_read_word: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_i.rd && (req_i.addr == OFS_IP_LO) |=> (rdata_o == $past(ip_lo_q)))
    else $error("network word read back wrong");

endmodule : asnr_regs

// ---- test/asnr_host.sv ----
// Remote host model issuing register requests to the bank
`timescale 1ns/1ps
module asnr_host (
  input  wire logic          ref_clk_i,
  input  wire logic [15:0]   rdata_i,
  output asnr_pkg::asnr_req_t req_o
);
  import asnr_pkg::*;
  initial req_o = '{wr: 1'b0, rd: 1'b0, fieldbus: 1'b0, addr: 8'h5a, wdata: 16'ha5a5};
  // Released bus shows inverted leftovers so stale values never match
  task automatic release_bus();
    req_o.wr    = 1'b0;
    req_o.rd    = 1'b0;
    req_o.addr  = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
  endtask : release_bus
  // Network load commands go over the fieldbus only when a test asks to misbehave
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data, input logic fb);
    @(negedge ref_clk_i);
    req_o.fieldbus = fb;
    req_o.addr     = addr;
    req_o.wdata    = data;
    req_o.wr       = 1'b1;
    @(negedge ref_clk_i);
    release_bus();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    @(negedge ref_clk_i);
    req_o.fieldbus = 1'b1;
    req_o.addr     = addr;
    req_o.rd       = 1'b1;
    @(negedge ref_clk_i);
    release_bus();
    @(negedge ref_clk_i);
    data = rdata_i;
  endtask : read_reg
endmodule : asnr_host

// ---- test/asnr_regs_tb.sv ----
// Self-checking bench for the status and network register bank
`timescale 1ns/1ps
module asnr_regs_tb;
  import asnr_pkg::*;
  logic               ref_clk_i;
  logic               rst_b_i;
  asnr_req_t          req;
  asnr_cond_t         cond;
  logic signed [15:0] enc_temp;
  logic               sw;
  logic [31:0]        moist;
  logic [15:0]        rdata;
  logic               relay;
  logic               fault;
  logic [1:0]         dec;
  logic [15:0]        rv;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 cycles = 0;
  logic [15:0] mask_exp = RST_SEL_MASK;
  logic [7:0]  net_ofs [6] = '{OFS_IP_HI, OFS_IP_LO, OFS_GW_HI, OFS_GW_LO, OFS_NM_HI, OFS_NM_LO};
  logic [15:0] net_rst [6] = '{RST_IP_HI, RST_IP_LO, RST_GW_HI, RST_GW_LO, RST_NM_HI, RST_NM_LO};
  logic [12:0] cond_tab [13] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0300, 13'h0080, 13'h0040,
                                 13'h0020, 13'h0010, 13'h0008, 13'h0004, 13'h0002, 13'h0001};
  logic [15:0] flag_tab [13] = '{16'h0001, 16'h0002, 16'h0004, 16'h0000, 16'h0008, 16'h0010, 16'h0040,
                                 16'h0080, 16'h0080, 16'h0100, 16'h0400, 16'h0800, 16'h0800};
  logic [15:0] temp_tab [4] = '{16'hffeb, 16'hffec, 16'h0046, 16'h0047};
  logic [15:0] trng_tab [4] = '{16'h0200, 16'h0000, 16'h0000, 16'h0200};
  logic [31:0] moist_tab [4] = '{32'd99999, 32'd100000, 32'd999999, 32'd1000000};
  logic [1:0]  dec_tab [4] = '{2'd2, 2'd1, 2'd1, 2'd0};

  asnr_regs dut (
    .ref_clk_i               (ref_clk_i),
    .rst_b_i                 (rst_b_i),
    .req_i                   (req),
    .cond_i                  (cond),
    .enc_temp_i              (enc_temp),
    .default_select_switch_i (sw),
    .moisture_i              (moist),
    .rdata_o                 (rdata),
    .status_alarm_relay_o    (relay),
    .third_output_fault_o    (fault),
    .display_decimals_o      (dec)
  );
  asnr_host host (
    .ref_clk_i (ref_clk_i),
    .rdata_i   (rdata),
    .req_o     (req)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Pulse conditions then read flags and outputs while nothing is live
  task automatic flag_case(input logic [12:0] c, input logic signed [15:0] t, input logic [15:0] exp);
    @(negedge ref_clk_i);
    cond     = c;
    enc_temp = t;
    @(negedge ref_clk_i);
    cond     = '0;
    enc_temp = 16'sd25;
    host.read_reg(OFS_FLAGS, rv);
    check("flags", rv, exp);
    check("relay", {15'h0, relay}, {15'h0, |(exp & mask_exp)});
    check("third out", {15'h0, fault}, {15'h0, |(exp & mask_exp)});
    host.write_reg(OFS_COMMAND, 16'h0018, 1'b0);
    host.read_reg(OFS_FLAGS, rv);
    check("flags clr", rv, 16'h0000);
    check("relay clr", {15'h0, relay}, 16'h0000);
    check("third out clr", {15'h0, fault}, 16'h0000);
  endtask : flag_case

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    rst_b_i  = 1'b0;
    cond     = '0;
    enc_temp = 16'sd25;
    sw       = 1'b0;
    moist    = '0;
    repeat (8) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      host.read_reg(net_ofs[i], rv);
      check("net reset", rv, net_rst[i]);
    end
    host.write_reg(OFS_IP_HI, 16'h0aff, 1'b0);
    host.read_reg(OFS_IP_HI, rv);
    check("ip octets", rv, 16'h0aff);
    // Refused over the fieldbus, honoured locally
    host.write_reg(OFS_COMMAND, 16'h0028, 1'b1);
    host.read_reg(OFS_IP_HI, rv);
    check("fieldbus cmd", rv, 16'h0aff);
    host.write_reg(OFS_COMMAND, 16'h0028, 1'b0);
    host.read_reg(OFS_IP_HI, rv);
    check("cmd defaults", rv, 16'hc0a8);
    sw = 1'b1;
    host.write_reg(OFS_NM_LO, 16'h1234, 1'b0);
    host.read_reg(OFS_NM_LO, rv);
    check("switch defaults", rv, 16'hff00);
    sw = 1'b0;
    host.write_reg(OFS_FLAGS, 16'hffff, 1'b0);
    host.read_reg(OFS_FLAGS, rv);
    check("flags ro", rv, 16'h0000);
    for (int i = 0; i < 13; i++) flag_case(cond_tab[i], 16'sd25, flag_tab[i]);
    flag_case('1, 16'sd100, 16'h0fdf);
    for (int i = 0; i < 4; i++) flag_case('0, temp_tab[i], trng_tab[i]);
    // Mask only the mirror sensor; enclosure fault must stay off the relay
    host.write_reg(OFS_SEL_MASK, 16'h0001, 1'b0);
    mask_exp = 16'h0001;
    host.read_reg(OFS_SEL_MASK, rv);
    check("sel mask", rv, mask_exp);
    flag_case(13'h0800, 16'sd25, 16'h0002);
    flag_case(13'h1000, 16'sd25, 16'h0001);
    host.write_reg(OFS_DP_SETPT, 16'hff9c, 1'b0);
    host.write_reg(OFS_ENC_SETPT, 16'hffce, 1'b0);
    host.write_reg(OFS_PRES_SETPT, 16'hfff6, 1'b0);
    host.read_reg(OFS_DP_SETPT, rv);
    check("int setpoint", rv, 16'hff9c);
    host.read_reg(OFS_ENC_SETPT, rv);
    check("enc setpoint", rv, 16'hffce);
    host.read_reg(OFS_PRES_SETPT, rv);
    check("tenths setpoint", rv, 16'hfff6);
    host.write_reg(OFS_TEMP_UNIT, 16'h0001, 1'b0);
    host.write_reg(OFS_PRES_UNIT, 16'h0001, 1'b0);
    host.read_reg(OFS_DP_SETPT, rv);
    check("dp restore", rv, RST_DP_SETPT);
    host.read_reg(OFS_ENC_SETPT, rv);
    check("enc restore", rv, RST_ENC_SETPT);
    host.read_reg(OFS_PRES_SETPT, rv);
    check("pres restore", rv, RST_PRES_SETPT);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk_i);
      moist = moist_tab[i];
      @(negedge ref_clk_i);
      check("decimals", {14'h0, dec}, {14'h0, dec_tab[i]});
    end
    final_report();
  end
endmodule : asnr_regs_tb
